// ==== shared/blp_pkg.sv ====
// constants and types for the backlight pwm driver
package blp_pkg;
    localparam int NUM_CH = 3;
    localparam int CH_MAIN = 0;
    localparam int CH_AUX = 1;
    localparam int CH_KEYPAD = 2;
    localparam int LEVEL_W = 3;
    localparam int DUTY_W = 6;
    localparam int SLOT_W = 5;
    localparam int CURRENT_W = 7;
    // clock and timing
    localparam longint CLK_HZ = 125000000;
    localparam longint PWM_RATE_HZ = 256;
    localparam longint SLOTS_PER_FRAME = 32;
    localparam longint RAMP_STEP_PER_S = 64;
    localparam longint SLOT_CYCLES = CLK_HZ / (PWM_RATE_HZ * SLOTS_PER_FRAME);
    localparam longint RAMP_FRAMES = PWM_RATE_HZ / RAMP_STEP_PER_S;
    localparam int SLOT_CNT_W = 16;
    localparam int RAMP_CNT_W = 3;
    // switcher startup stretch added to each on period, in clock cycles
    localparam int STRETCH_CYCLES = 2000;
    localparam int STRETCH_W = 12;
    // current step per code in milliamps
    localparam logic [CURRENT_W-1:0] STEP_LOW_MA = 7'h03;
    localparam logic [CURRENT_W-1:0] STEP_HIGH_MA = 7'h06;
    localparam logic [DUTY_W-1:0] DUTY_OFF = 6'h00;
    localparam logic [DUTY_W-1:0] DUTY_FULL = 6'h20;
    localparam int DUTY_FULL_BIT = 5;
    typedef enum logic [1:0] {
        BLP_ONE = 2'b00,
        BLP_SHARE_A = 2'b01,
        BLP_SHARE_B = 2'b11,
        BLP_LOCKOUT = 2'b10
    } blp_share_t;
endpackage

// ==== verilog/blp_driver.sv ====
// three channel backlight pwm driver with ramp and time sharing
module blp_driver #(
    // slot length and on-time stretch in clock cycles
    parameter int SLOT_CYCLES = int'(blp_pkg::SLOT_CYCLES),
    parameter int STRETCH_CYCLES = blp_pkg::STRETCH_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // per-channel controls, index 0 main, 1 aux, 2 keypad
    input wire logic [2:0] channel_enable_bit,
    input wire logic [2:0] ramp_enable_bit,
    input wire logic [2:0] high_range_select,
    input wire logic [2:0][blp_pkg::LEVEL_W-1:0] current_level_code,
    input wire logic [2:0][blp_pkg::DUTY_W-1:0] duty_code,
    // sink drive, working duty and frame marker outputs
    output logic main_display_sink,
    output logic aux_display_sink,
    output logic keypad_sink,
    output logic [2:0][blp_pkg::CURRENT_W-1:0] sink_current_ma,
    output logic [2:0][blp_pkg::DUTY_W-1:0] active_duty,
    output logic frame_start
);
    logic [blp_pkg::SLOT_CNT_W-1:0] slot_cnt_q;
    logic [blp_pkg::SLOT_W-1:0] slot_q;
    logic slot_tick;
    logic frame_tick;
    logic [blp_pkg::RAMP_CNT_W-1:0] ramp_cnt_q;
    logic ramp_tick;
    logic [2:0] active_ch;
    logic [1:0] n_active;
    blp_pkg::blp_share_t share_q;
    logic [2:0][blp_pkg::DUTY_W-1:0] duty_q;
    logic [2:0][blp_pkg::LEVEL_W-1:0] level_q;
    logic [2:0] hi_q;
    logic [2:0] pwm_raw;
    logic [2:0] pwm_on;
    logic [2:0] gate;
    logic [2:0] sink_q;
    logic [2:0][blp_pkg::CURRENT_W-1:0] cur_q;

    // slot divider and 32-slot frame counter
    assign slot_tick = (slot_cnt_q == blp_pkg::SLOT_CNT_W'(SLOT_CYCLES - 1));
    assign frame_tick = slot_tick && (slot_q == blp_pkg::SLOT_W'(blp_pkg::SLOTS_PER_FRAME - 1));
    always_ff @(posedge clk) begin
        if (srst) begin
            slot_cnt_q <= '0;
            slot_q <= '0;
        end else if (slot_tick) begin
            slot_cnt_q <= '0;
            slot_q <= slot_q + 1'b1;
        end else begin
            slot_cnt_q <= slot_cnt_q + 1'b1;
        end
    end

    // ramp step strobe every 1/64 s, counted in frames
    assign ramp_tick = frame_tick && (ramp_cnt_q == blp_pkg::RAMP_CNT_W'(blp_pkg::RAMP_FRAMES - 1));
    always_ff @(posedge clk) begin
        if (srst) begin
            ramp_cnt_q <= '0;
        end else if (ramp_tick) begin
            ramp_cnt_q <= '0;
        end else if (frame_tick) begin
            ramp_cnt_q <= ramp_cnt_q + 1'b1;
        end
    end

    // per-channel duty tracking, level latch and pwm compare
    genvar gi;
    generate
        for (gi = 0; gi < blp_pkg::NUM_CH; gi++) begin : g_ch
            logic [blp_pkg::DUTY_W-1:0] target;
            logic [blp_pkg::STRETCH_W-1:0] stretch_q;
            // codes 32..63 all mean full on
            assign target = duty_code[gi][blp_pkg::DUTY_FULL_BIT] ? blp_pkg::DUTY_FULL
                                                                 : duty_code[gi];
            always_ff @(posedge clk) begin
                if (srst) begin
                    duty_q[gi] <= blp_pkg::DUTY_OFF;
                    level_q[gi] <= '0;
                    hi_q[gi] <= 1'b0;
                end else if (frame_tick) begin
                    level_q[gi] <= current_level_code[gi];
                    hi_q[gi] <= high_range_select[gi];
                    if (!ramp_enable_bit[gi]) begin
                        duty_q[gi] <= target;
                    end else if (ramp_tick && duty_q[gi] < target) begin
                        duty_q[gi] <= duty_q[gi] + 1'b1;
                    end else if (ramp_tick && duty_q[gi] > target) begin
                        duty_q[gi] <= duty_q[gi] - 1'b1;
                    end
                end
            end
            assign pwm_raw[gi] = (duty_q[gi][blp_pkg::DUTY_FULL_BIT])
                || ({1'b0, slot_q} < duty_q[gi]);
            // hold the sink on a little past the nominal on-time
            always_ff @(posedge clk) begin
                if (srst) begin
                    stretch_q <= '0;
                end else if (pwm_raw[gi]) begin
                    stretch_q <= blp_pkg::STRETCH_W'(STRETCH_CYCLES);
                end else if (stretch_q != '0) begin
                    stretch_q <= stretch_q - 1'b1;
                end
            end
            assign pwm_on[gi] = pwm_raw[gi] || (stretch_q != '0);
            assign active_ch[gi] = channel_enable_bit[gi] && (duty_q[gi] != blp_pkg::DUTY_OFF);
        end
    endgenerate

    assign n_active = 2'(active_ch[0]) + 2'(active_ch[1]) + 2'(active_ch[2]);

    // sharing state: one driver, alternating pair, or lockout
    always_ff @(posedge clk) begin
        if (srst) begin
            share_q <= blp_pkg::BLP_ONE;
        end else begin
            case (n_active)
                2'd3: share_q <= blp_pkg::BLP_LOCKOUT;
                2'd2: begin
                    if (slot_tick) begin
                        share_q <= (share_q == blp_pkg::BLP_SHARE_A) ? blp_pkg::BLP_SHARE_B
                                                                   : blp_pkg::BLP_SHARE_A;
                    end else if (share_q == blp_pkg::BLP_ONE || share_q == blp_pkg::BLP_LOCKOUT) begin
                        share_q <= blp_pkg::BLP_SHARE_A;
                    end
                end
                default: share_q <= blp_pkg::BLP_ONE;
            endcase
        end
    end

    // gate selection: lower index channel takes slot a, higher takes slot b
    always_comb begin
        gate = 3'b000;
        case (share_q)
            blp_pkg::BLP_ONE: gate = active_ch;
            blp_pkg::BLP_SHARE_A: gate = active_ch & ~(active_ch - 3'b001) ; // lowest set bit
            blp_pkg::BLP_SHARE_B: gate = active_ch & (active_ch - 3'b001); // remaining bit
            blp_pkg::BLP_LOCKOUT: gate = 3'b000;
            default: gate = 3'b000;
        endcase
    end

    // registered sink enables and current setting
    always_ff @(posedge clk) begin
        if (srst) begin
            sink_q <= 3'b000;
            cur_q <= '0;
        end else begin
            for (int i = 0; i < blp_pkg::NUM_CH; i++) begin
                sink_q[i] <= gate[i] && pwm_on[i] && (n_active != 2'd3);
                cur_q[i] <= level_to_ma(level_q[i], hi_q[i], n_active == 2'd2);
            end
        end
    end

    function automatic logic [blp_pkg::CURRENT_W-1:0] level_to_ma(
        input logic [blp_pkg::LEVEL_W-1:0] lvl,
        input logic hi,
        input logic dbl
    );
        logic [blp_pkg::CURRENT_W-1:0] step;
        logic [blp_pkg::CURRENT_W-1:0] base;
        step = hi ? blp_pkg::STEP_HIGH_MA : blp_pkg::STEP_LOW_MA;
        base = 7'(step * {4'h0, lvl});
        return dbl ? 7'(base << 1) : base;
    endfunction

    // frame marker register
    always_ff @(posedge clk) begin
        if (srst) begin
            frame_start <= 1'b0;
        end else begin
            frame_start <= frame_tick;
        end
    end

    // registered copy of the working duty of each channel
    always_ff @(posedge clk) begin
        if (srst) begin
            active_duty <= '0;
        end else begin
            active_duty <= duty_q;
        end
    end

    assign main_display_sink = sink_q[blp_pkg::CH_MAIN];
    assign aux_display_sink = sink_q[blp_pkg::CH_AUX];
    assign keypad_sink = sink_q[blp_pkg::CH_KEYPAD];
    assign sink_current_ma = cur_q;
endmodule

// ==== test/blp_driver_properties.sv ====
// port assertions for the backlight pwm driver
module blp_driver_properties (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // controls
    input wire logic [2:0] channel_enable_bit,
    input wire logic [2:0] ramp_enable_bit,
    // sink, working duty and frame marker outputs
    input wire logic main_display_sink,
    input wire logic aux_display_sink,
    input wire logic keypad_sink,
    input wire logic [2:0][blp_pkg::CURRENT_W-1:0] sink_current_ma,
    input wire logic [2:0][blp_pkg::DUTY_W-1:0] active_duty,
    input wire logic frame_start
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    logic lock;
    logic any_sink;
    logic main_seen_q;
    // remembers that the main sink has been on since reset
    always_ff @(posedge clk) begin
        if (srst) begin
            main_seen_q <= 1'b0;
        end else if (main_display_sink) begin
            main_seen_q <= 1'b1;
        end
    end
    // all three channels active means lockout
    assign lock = (&channel_enable_bit) && (active_duty[0] != 6'h00)
        && (active_duty[1] != 6'h00) && (active_duty[2] != 6'h00);
    assign any_sink = main_display_sink | aux_display_sink | keypad_sink;
    a_reset_quiet: assert property (disable iff (1'b0) srst |=> !any_sink && !frame_start
        && active_duty == '0) else $error("outputs not quiet after reset");
    a_lockout_dark: assert property (lock && $past(lock) |-> !any_sink)
        else $error("sink on during lockout");
    a_main_disabled: assert property (!channel_enable_bit[0] [*2] |-> !main_display_sink)
        else $error("main sink on while disabled");
    a_frame_pulse: assert property (frame_start |=> !frame_start [*8])
        else $error("frame pulse too long");
    a_duty_cap: assert property (active_duty[0] <= 6'h20 && active_duty[1] <= 6'h20
        && active_duty[2] <= 6'h20) else $error("working duty above full");
    a_duty_hold: assert property (!$past(frame_start) |-> $stable(active_duty))
        else $error("duty changed off frame edge");
    a_current_steps: assert property (sink_current_ma[0] % 3 == 0
        && sink_current_ma[0] <= 7'h54) else $error("main current off step");
    a_ramp_step: assert property ($changed(active_duty[0]) && ramp_enable_bit[0]
        |-> active_duty[0] == $past(active_duty[0]) + 6'h01
        || active_duty[0] == $past(active_duty[0]) - 6'h01) else $error("ramp jump");
    c_lockout: cover property (lock);
    c_frame: cover property (frame_start);
    c_share: cover property (main_seen_q && keypad_sink);
endmodule

// ==== test/tb.sv ====
// self-checking bench for the backlight pwm driver
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [2:0] en;
        logic [2:0] hi;
        logic [2:0][2:0] lvl;
        logic [2:0][5:0] duty;
        logic [6:0] cur0;
        logic [6:0] cur2;
        logic [5:0] ad0;
        logic lock;
    } blp_row_t;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] en = 3'h0;
    logic [2:0] ramp = 3'h0;
    logic [2:0] hi = 3'h0;
    logic [2:0][2:0] lvl = '0;
    logic [2:0][5:0] duty = '0;
    logic main_s, aux_s, kp_s, fs;
    logic [2:0][6:0] cur;
    logic [2:0][5:0] ad;
    int bad_count = 0;
    int samples_checked = 0;
    blp_row_t rows [3] = '{
        '{3'h1, 3'h0, {3'h0, 3'h0, 3'h7}, {6'h00, 6'h00, 6'h10}, 7'h15, 7'h00, 6'h10, 1'b0},
        '{3'h5, 3'h4, {3'h5, 3'h0, 3'h5}, {6'h3F, 6'h00, 6'h28}, 7'h1E, 7'h3C, 6'h20, 1'b0},
        '{3'h7, 3'h0, {3'h1, 3'h1, 3'h1}, {6'h01, 6'h01, 6'h01}, 7'h00, 7'h00, 6'h01, 1'b1}};
    always #4 clk = ~clk;
    blp_driver #(.SLOT_CYCLES(8), .STRETCH_CYCLES(2)) dut (.clk(clk), .srst(srst),
        .channel_enable_bit(en), .ramp_enable_bit(ramp),
        .high_range_select(hi), .current_level_code(lvl), .duty_code(duty),
        .main_display_sink(main_s), .aux_display_sink(aux_s), .keypad_sink(kp_s),
        .sink_current_ma(cur), .active_duty(ad), .frame_start(fs));
    // compare one value and count it
    task automatic check(string name, logic [6:0] seen, logic [6:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    // wait for n frame marker pulses, sampled just after the edge
    task automatic wait_frames(int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            while (fs !== 1'b1) begin
                @(posedge clk);
                #1;
            end
        end
    endtask
    // counts, verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // main sequence
    initial begin
        logic sm, sk;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            en <= rows[i].en;
            hi <= rows[i].hi;
            lvl <= rows[i].lvl;
            duty <= rows[i].duty;
            wait_frames(1);
            repeat (2) @(posedge clk);
            #1;
            check("duty0", ad[0], rows[i].ad0);
            sm = 1'b0;
            sk = 1'b0;
            repeat (512) begin
                @(posedge clk);
                #1;
                sm |= main_s;
                sk |= kp_s | aux_s;
            end
            if (rows[i].lock) begin
                check("dark", {5'h0, sm, sk}, 7'h00);
            end else if (rows[i].en[2]) begin
                check("cur0", cur[0], rows[i].cur0);
                check("cur2", cur[2], rows[i].cur2);
                check("duty2", ad[2], 6'h20);
                check("share", {5'h0, sm, sk}, 7'h03);
            end else begin
                check("cur0", cur[0], rows[i].cur0);
                check("main", {6'h0, sm}, 7'h01);
            end
            $display("row %0d done", i);
            @(posedge clk);
        end
        // reset in mid-run clears everything
        srst <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        check("rst", {3'h0, main_s, aux_s, kp_s, fs}, 7'h00);
        check("rstduty", ad[0], 6'h00);
        check("rstcur", cur[0], 7'h00);
        $display("reset test done");
        // ramp from zero toward eight, one step per four frames
        @(posedge clk);
        srst <= 1'b0;
        en <= 3'h1;
        ramp <= 3'h1;
        duty <= {6'h00, 6'h00, 6'h08};
        wait_frames(8);
        repeat (2) @(posedge clk);
        #1;
        check("ramp", ad[0], 6'h02);
        // ramp off: the setting lands at the next frame
        @(posedge clk);
        ramp <= 3'h0;
        wait_frames(1);
        repeat (2) @(posedge clk);
        #1;
        check("jump", ad[0], 6'h08);
        $display("ramp test done");
        print_verdict();
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
endmodule
bind blp_driver blp_driver_properties chk (.clk(clk), .srst(srst),
    .channel_enable_bit(channel_enable_bit), .ramp_enable_bit(ramp_enable_bit),
    .main_display_sink(main_display_sink), .aux_display_sink(aux_display_sink),
    .keypad_sink(keypad_sink), .sink_current_ma(sink_current_ma),
    .active_duty(active_duty), .frame_start(frame_start));
